// file: hdl/usb_host_command_event_regs.v
// command/status and event-flag registers of the usb host controller
// assumes the command port and event inputs come from logic on clk
//
// Overview of operation
// - command/status writes set ones, zeros leave bits unchanged
// - command/status read with code 02h, written with 82h
// - every command/status bit reads back its current value
// - overrun when periodic list unfinished at end of frame
// - each overrun bumps the counter and sets the overrun flag
// - two-bit read-only counter in bits 17:16, from 00 wrapping after 11
// - counter advances even when the overrun flag is still set
// - soft reset enters suspended state, resets registers, refuses bus
// - controller clears the soft reset bit when reset finishes
// - soft reset finishes within 10 microseconds
// - soft reset leaves root hub and downstream ports untouched
// - each interrupt-capable event sets its event flag
// - interrupt when flag and its enable and master enable are set
// - writing one clears a flag, zero keeps it, writes never set
// - internal logic sets flags and clears them only during soft reset
// - event flags read with code 03h, written with 83h
// - overrun flag is bit 0 of the event flags
// - master enable bit 31; when zero no interrupt at all
`timescale 1ns/10ps
`default_nettype none
`include "usb_host_cmd_consts.vh"

module usb_host_command_event_regs (
    input wire clk,
    input wire rstn,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [31:0] wr_data,
    output wire cmd_ready,
    output wire [31:0] rd_data,
    output wire rd_valid,
    input wire eof_pulse,
    input wire periodic_done,
    input wire [6:0] event_in,
    input wire [31:0] event_enable_register,
    input wire fs_load,
    input wire [1:0] fs_value,
    output wire [1:0] functional_state_field,
    output wire soft_reset_active,
    output wire irq
);

    // ********************************************
    // control states
    // ********************************************
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_SRST = 2'b10;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;

    // ********************************************
    // register storage
    // ********************************************
    reg hcr_ff;
    reg nxt_hcr;
    reg [1:0] soc_ff;
    reg [1:0] nxt_soc;
    reg [1:0] fs_ff;
    reg [1:0] nxt_fs;
    reg [31:0] rd_data_ff;
    reg [31:0] nxt_rd_data;
    reg rd_valid_ff;
    reg nxt_rd_valid;
    reg irq_ff;
    reg nxt_irq;

    wire [6:0] flags;
    wire [6:0] flag_set;
    wire [6:0] flag_clr;
    wire [31:0] cmdstat_word;
    wire [31:0] evflag_word;

    // ********************************************
    // command decode
    // ********************************************
    wire srst_busy;
    wire srst_done;
    wire accept;
    wire wr_cs;
    wire wr_ef;
    wire rd_cs;
    wire rd_ef;
    wire srst_start;

    // refused while soft reset is in progress
    assign cmd_ready = (state_ff != ST_SRST);
    assign accept = cmd_valid && cmd_ready;

    assign wr_cs = accept && (cmd_code == `CMD_WR_CMDSTAT);
    assign rd_cs = accept && (cmd_code == `CMD_RD_CMDSTAT);
    assign wr_ef = accept && (cmd_code == `CMD_WR_EVFLAG);
    assign rd_ef = accept && (cmd_code == `CMD_RD_EVFLAG);

    // only a rising set of the reset bit starts a reset
    assign srst_start = wr_cs && wr_data[`CS_HCR_BIT] && !hcr_ff;

    // ********************************************
    // soft reset timer
    // ********************************************
    soft_reset_timer u_srst (
        .clk(clk),
        .rstn(rstn),
        .start(srst_start),
        .busy(srst_busy),
        .done(srst_done)
    );

    // only the operational registers here see this; the root hub
    // and port reset paths are driven from hardware reset alone
    assign soft_reset_active = srst_busy;

    // ********************************************
    // control state machine
    // ********************************************
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (srst_start) begin
                    nxt_state = ST_SRST;
                end
            end
            ST_SRST: begin
                if (srst_done) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // ********************************************
    // command/status register
    // ********************************************
    wire overrun;

    // periodic list still running when the frame ends
    assign overrun = eof_pulse && !periodic_done;

    always @* begin
        nxt_hcr = hcr_ff;
        nxt_soc = soc_ff;
        if (wr_cs && wr_data[`CS_HCR_BIT]) begin
            nxt_hcr = 1'b1;
        end
        if (srst_done) begin
            nxt_hcr = 1'b0;
        end
        if (overrun) begin
            // no check of the overrun flag here on purpose
            nxt_soc = soc_ff + 2'h1;
        end
        if (srst_busy) begin
            nxt_soc = `CS_SOC_RESET;
        end
    end

    // counter is never written by software
    assign cmdstat_word = {14'h0000, soc_ff, 15'h0000, hcr_ff};

    // ********************************************
    // functional state
    // ********************************************
    always @* begin
        nxt_fs = fs_ff;
        if (srst_start || srst_busy) begin
            nxt_fs = `FS_SUSPEND;
        end else if (fs_load) begin
            nxt_fs = fs_value;
        end
    end

    assign functional_state_field = fs_ff;

    // ********************************************
    // event flags
    // ********************************************
    // bit 1 and bit 7 up are reserved; the mask keeps bit 1 zero, the read word pads bits 7 up with zeros
    assign flag_set = {event_in[6:1], event_in[0] | overrun} & `EF_VALID_MASK;
    assign flag_clr = wr_ef ? wr_data[6:0] : 7'h00;

    event_flag_bits #(
        .W(`EF_WIDTH),
        .MASK(`EF_VALID_MASK)
    ) u_flags (
        .clk(clk),
        .rstn(rstn),
        .flush(srst_busy),
        .set(flag_set),
        .clr(flag_clr),
        .flags(flags)
    );

    assign evflag_word = {25'h0000000, flags};

    // ********************************************
    // interrupt request
    // ********************************************
    always @* begin
        nxt_irq = 1'b0;
        if (event_enable_register[`EN_MIE_BIT]) begin
            nxt_irq = |(flags & event_enable_register[6:0]);
        end
    end

    assign irq = irq_ff;

    // ********************************************
    // read path
    // ********************************************
    // unknown codes with bit 7 clear answer with zero so the host never hangs; codes with bit 7 set get no answer
    always @* begin
        nxt_rd_valid = accept && !cmd_code[7];
        nxt_rd_data = 32'h00000000;
        if (rd_cs) begin
            nxt_rd_data = cmdstat_word;
        end else if (rd_ef) begin
            nxt_rd_data = evflag_word;
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;

    // ********************************************
    // flops
    // ********************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_RUN;
            hcr_ff <= `CS_HCR_RESET;
            soc_ff <= `CS_SOC_RESET;
            fs_ff <= `FS_RESET;
            rd_data_ff <= 32'h00000000;
            rd_valid_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hcr_ff <= nxt_hcr;
            soc_ff <= nxt_soc;
            fs_ff <= nxt_fs;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            irq_ff <= nxt_irq;
        end
    end

endmodule
`default_nettype wire

// file: hdl/usb_host_cmd_consts.vh
// constants for the command/status and event-flag register bank
// assumes a 20 MHz controller clock; included by bare name
`ifndef USB_HOST_CMD_CONSTS_VH
`define USB_HOST_CMD_CONSTS_VH

// ********************************************
// bus command codes
// ********************************************
`define CMD_RD_CMDSTAT 8'h02
`define CMD_WR_CMDSTAT 8'h82
`define CMD_RD_EVFLAG 8'h03
`define CMD_WR_EVFLAG 8'h83

// ********************************************
// field positions
// ********************************************
`define CS_HCR_BIT 0
`define CS_SOC_LSB 16
`define CS_SOC_MSB 17
`define EF_SO_BIT 0
`define EF_WIDTH 7
`define EF_VALID_MASK 7'h7d
`define EN_MIE_BIT 31

// ********************************************
// reset values
// ********************************************
`define CS_HCR_RESET 1'b0
`define CS_SOC_RESET 2'h0
`define EF_RESET 7'h00
`define FS_RESET 2'h0
`define FS_SUSPEND 2'h3

// ********************************************
// timing
// ********************************************
`define CLK_PERIOD_NS 50
`define SRST_MAX_NS 10000
// longest time, so round down
`define SRST_CYCLES ((`SRST_MAX_NS) / (`CLK_PERIOD_NS))

`endif

// file: hdl/soft_reset_timer.v
// counts out the controller soft reset window
// assumes start is a one-cycle pulse on clk
`timescale 1ns/10ps
`default_nettype none
`include "usb_host_cmd_consts.vh"

module soft_reset_timer (
    input wire clk,
    input wire rstn,
    input wire start,
    output wire busy,
    output wire done
);
    localparam integer SRST_N = `SRST_CYCLES;

    reg [7:0] cnt_ff;
    reg busy_ff;
    reg [7:0] nxt_cnt;
    reg nxt_busy;

    assign busy = busy_ff;
    assign done = busy_ff && ({24'h0, cnt_ff} == SRST_N - 1);

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        if (done) begin
            nxt_busy = 1'b0;
            nxt_cnt = 8'h00;
        end else if (busy_ff) begin
            nxt_cnt = cnt_ff + 8'h01;
        end else if (start) begin
            nxt_busy = 1'b1;
            nxt_cnt = 8'h00;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
        end
    end
endmodule
`default_nettype wire

// file: hdl/event_flag_bits.v
// sticky event flags: hardware sets, software clears with ones
// assumes set and clear come from logic on clk
`timescale 1ns/10ps
`default_nettype none

module event_flag_bits #(
    parameter W = 7,
    parameter [W-1:0] MASK = {W{1'b1}}
) (
    input wire clk,
    input wire rstn,
    input wire flush,
    input wire [W-1:0] set,
    input wire [W-1:0] clr,
    output wire [W-1:0] flags
);
    reg [W-1:0] flags_ff;
    reg [W-1:0] nxt_flags;

    assign flags = flags_ff;

    // set wins over a clear in the same cycle
    always @* begin
        nxt_flags = ((flags_ff & ~clr) | set) & MASK;
        if (flush) begin
            nxt_flags = {W{1'b0}};
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_ff <= {W{1'b0}};
        end else begin
            flags_ff <= nxt_flags;
        end
    end
endmodule
`default_nettype wire

// file: tb/usb_host_command_event_regs_assertions.sv
// port-level checker for the command/event register bank
// assumes it is bound to the top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module usb_host_command_event_regs_assertions (
    input wire clk,
    input wire rstn,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [31:0] wr_data,
    input wire cmd_ready,
    input wire [31:0] rd_data,
    input wire rd_valid,
    input wire eof_pulse,
    input wire periodic_done,
    input wire [31:0] event_enable_register,
    input wire [1:0] functional_state_field,
    input wire soft_reset_active,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [8:0] busy_cnt_ff;
    // counts cycles of soft reset; 200 cycles is the 10 us ceiling
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            busy_cnt_ff <= 9'h000;
        else
            busy_cnt_ff <= soft_reset_active ? busy_cnt_ff + 9'h001 : 9'h000;
    end
    rd_answer_a: assert property (cmd_valid && cmd_ready && !cmd_code[7] |=> rd_valid)
        else $error("read not answered");
    no_stray_a: assert property (!(cmd_valid && cmd_ready && !cmd_code[7]) |=> !rd_valid)
        else $error("answer without read");
    cs_rsvd_a: assert property (cmd_valid && cmd_ready && cmd_code == 8'h02
        |=> rd_data[31:18] == 14'h0000 && rd_data[15:1] == 15'h0000) else $error("status reserved set");
    ef_rsvd_a: assert property (cmd_valid && cmd_ready && cmd_code == 8'h03
        |=> rd_data[31:7] == 25'h0000000 && !rd_data[1]) else $error("flag reserved set");
    srst_start_a: assert property (cmd_valid && cmd_ready && cmd_code == 8'h82 && wr_data[0]
        |=> soft_reset_active && !cmd_ready && functional_state_field == 2'h3) else $error("soft reset not begun");
    srst_len_a: assert property (soft_reset_active |-> busy_cnt_ff < 9'd200)
        else $error("soft reset too long");
    srst_refuse_a: assert property (soft_reset_active |-> !cmd_ready)
        else $error("ready during soft reset");
    irq_gate_a: assert property (!event_enable_register[31] |=> !irq)
        else $error("irq with master enable off");
    irq_raise_a: assert property ((eof_pulse && !periodic_done && !soft_reset_active ##1
        event_enable_register[0] && event_enable_register[31] && !soft_reset_active) |=> irq)
        else $error("irq missing");
endmodule
bind usb_host_command_event_regs usb_host_command_event_regs_assertions usb_host_command_event_regs_assertions_i (
    .clk, .rstn, .cmd_valid, .cmd_code, .wr_data, .cmd_ready, .rd_data, .rd_valid, .eof_pulse,
    .periodic_done, .event_enable_register, .functional_state_field, .soft_reset_active, .irq);
`default_nettype wire

// file: tb/host_driver_model.sv
// driver-side model that issues bus command codes
// assumes it is called on a falling edge of clk
`timescale 1ns/10ps
`default_nettype none
module host_driver_model (
    input wire logic clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [31:0] wr_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        wr_data = 32'h0;
    end
    // idle bus scrambled so a stale value never passes for data
    task automatic issue(input logic [7:0] c, input logic [31:0] d, input bit wait_rdy, output bit ok);
        int n;
        n = 0;
        @(negedge clk);
        while (wait_rdy && cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_code = c;
        wr_data = d;
        @(posedge clk);
        ok = (cmd_ready === 1'b1);
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code = ~c;
        wr_data = ~d;
    endtask
endmodule
`default_nettype wire

// file: tb/usb_host_command_event_regs_tb.sv
// self-checking bench for the command/event register bank
// assumes the host model drives commands on falling edges
`timescale 1ns/10ps
`default_nettype none
module usb_host_command_event_regs_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic eof_pulse = 1'b0;
    logic periodic_done = 1'b0;
    logic fs_load = 1'b0;
    logic [1:0] fs_value = 2'h0;
    logic [6:0] event_in = 7'h00;
    logic [31:0] event_enable_register = 32'h8000_007d;
    wire logic cmd_valid, cmd_ready, rd_valid, soft_reset_active, irq;
    wire logic [7:0] cmd_code;
    wire logic [31:0] wr_data, rd_data;
    wire logic [1:0] functional_state_field;
    logic [31:0] exp_q[$];
    logic [1:0] cnt = 2'h0;
    logic [6:0] fl = 7'h00;
    logic [31:0] d;
    int errors = 0;
    int n_checks = 0;
    int seed = 77;
    bit ok;
    always #25 clk = ~clk;
    usb_host_command_event_regs usb_host_command_event_regs_i (.clk, .rstn, .cmd_valid, .cmd_code,
        .wr_data, .cmd_ready, .rd_data, .rd_valid, .eof_pulse, .periodic_done, .event_in,
        .event_enable_register, .fs_load, .fs_value, .functional_state_field, .soft_reset_active, .irq);
    host_driver_model host_driver_model_i (.clk, .cmd_ready, .cmd_valid, .cmd_code, .wr_data);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] v);
        if (!c[7])
            exp_q.push_back(v);
        host_driver_model_i.issue(c, v, 1'b1, ok);
        chk({31'h0, ok}, 32'h1);
        if (!ok)
            end_sim;
    endtask
    task automatic ev(input logic eof, input logic pd, input logic [6:0] e);
        eof_pulse = eof;
        periodic_done = pd;
        event_in = e;
        @(negedge clk);
        eof_pulse = 1'b0;
        event_in = 7'h00;
        @(negedge clk);
    endtask
    // ****
    // answers are matched against the oldest note
    // ****
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk(32'h0, 32'h1);
            else
                chk(rd_data, exp_q.pop_front());
        end
    end
    initial begin
        #1000000;
        chk(32'h0, 32'h1);
        end_sim;
    end
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        cmd(8'h02, 32'h0);
        cmd(8'h03, 32'h0);
        fs_load = 1'b1;
        fs_value = 2'h2;
        @(negedge clk);
        fs_load = 1'b0;
        chk({30'h0, functional_state_field}, 32'h2);
        for (int i = 0; i < 6; i++) begin
            ev(1'b1, i == 5, 7'h00);
            if (i < 5)
                cnt++;
        end
        fl[0] = 1'b1;
        cmd(8'h02, {14'h0, cnt, 16'h0});
        cmd(8'h03, {25'h0, fl});
        cmd(8'h82, 32'hfffe_fffe);
        cmd(8'h02, {14'h0, cnt, 16'h0});
        repeat (6) begin
            event_enable_register = $random(seed);
            d = $random(seed);
            ev(1'b0, 1'b1, d[6:0] & 7'h7c);
            fl = fl | (d[6:0] & 7'h7c);
            cmd(8'h03, {25'h0, fl});
            d = $random(seed);
            cmd(8'h83, d);
            fl = fl & ~d[6:0];
            cmd(8'h03, {25'h0, fl});
        end
        event_enable_register = 32'h8000_0001;
        ev(1'b1, 1'b0, 7'h00);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        event_enable_register = 32'h0000_0001;
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        event_enable_register = 32'h8000_0001;
        cmd(8'h82, 32'h1);
        host_driver_model_i.issue(8'h02, 32'h0, 1'b0, ok);
        chk({31'h0, ok}, 32'h0);
        ev(1'b1, 1'b0, 7'h7c);
        chk({30'h0, functional_state_field}, 32'h3);
        cmd(8'h02, 32'h0);
        cmd(8'h03, 32'h0);
        repeat (2) @(negedge clk);
        chk(exp_q.size(), 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
